// File: hw/emb_defs.vh
// Register offsets, field positions, reset values and timing counts for the external bus control
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH

// Register byte offsets
`define EMB_CFG_OFS 8'h00
`define EMB_CFG2_OFS 8'h04
`define EMB_REQ_OFS 8'h08
`define EMB_STAT_OFS 8'h0C
`define EMB_IRQ_OFS 8'h10
`define EMB_MASK_OFS 8'h14
`define EMB_ADDR_OFS 8'h18
`define EMB_RDATA_OFS 8'h1C

// chip_config_word fields
`define EMB_CFG_WIDTH16_BIT 1
`define EMB_CFG_ADV_BIT 2
`define EMB_CFG_RST 8'h02
// chip_config_word_two fields
`define EMB_CFG2_WIDTH8_BIT 2
`define EMB_CFG2_RST 8'h04

// Request register fields
`define EMB_REQ_GO_BIT 0
`define EMB_REQ_READ_BIT 1
`define EMB_REQ_FETCH_BIT 2

// Interrupt status fields
`define EMB_IRQ_NMI_BIT 0
`define EMB_IRQ_DONE_BIT 1
`define EMB_IRQ_HOLD_BIT 2
`define EMB_IRQ_ILLEGAL_BIT 3
`define EMB_IRQ_W 4

// Non-maskable vector location
`define EMB_NMI_VECTOR 24'h00203E

// On-chip program window
`define EMB_ONCHIP_LO 24'hFF2000
`define EMB_ONCHIP_HI 24'hFF9FFF

// Bus cycle phase length in divided clock phases
`define EMB_PHASE_CYC 2'd2

`endif

// File: hw/emb_bus_ctrl.v
// External memory bus control with AXI4-Lite register access
// What this block does
// - Drive divided clock at half oscillator rate, equal high and low phases.
// - Config bit1 and config-two bit2 both set: width select input picks width.
// - Width select low gives 8-bit cycle, high gives 16-bit cycle.
// - Fixed 8-bit or 16-bit cycles from config bits; both zero is illegal.
// - Rising edge on NMI input raises NMI interrupt at fixed vector, maskable at irq by mask bit 0.
// - Fetch indicator high for instruction fetch reads, valid whole bus cycle.
// - Fetch indicator only for external fetches, low for on-chip fetches.
// - External access high maps upper program window on-chip, low off-chip.
// - External access level captured at reset and used afterwards.
// - Programming level on external access at reset enters programming mode.
// - Hold acknowledge shows the bus was released to the requester.
// - While held, bus request asserted when an external cycle is pending.
// - Address strobe works as latch enable or address valid per config bit.
// - Address valid mode returns strobe high at end of every bus cycle.
// - Address strobe pulses only on external accesses.
// - Read strobe low only on external reads; high elsewhere in bus cycles after the first address-phase cycle, general port pin otherwise.
// - Read strobe and fetch indicator act as general port pins when bus function unused; address strobe only in latch enable mode.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "emb_defs.vh"

module emb_bus_ctrl #(
	parameter ADDR_W = 24,
	parameter DATA_W = 16
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pins
	output reg divided_clock_output,
	input wire width_select_in,
	input wire nmi_in,
	input wire external_access_input,
	input wire external_access_prog,
	output reg fetch_indicator,
	output reg address_valid_strobe,
	output reg read_strobe_n,
	input wire hold_request,
	output reg hold_acknowledge_output,
	output reg pending_cycle_request,
	output reg [ADDR_W-1:0] bus_addr,
	input wire [DATA_W-1:0] bus_data_in,
	output reg bus_width16,
	// General port pin values when bus functions are off
	input wire [3:0] general_port_pin,
	// Status
	output reg programming_mode,
	output reg [ADDR_W-1:0] nmi_vector,
	output wire irq
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_ADDR = 4'b0010;
	localparam ST_DATA = 4'b0100;
	localparam ST_END = 4'b1000;
	// Phase counter reload, counts down to zero
	localparam [1:0] PH_LAST = `EMB_PHASE_CYC - 2'd1;

	reg [7:0] cfg_q;
	reg [7:0] cfg2_q;
	reg [7:0] mask_q;
	reg [`EMB_IRQ_W-1:0] irq_q;
	reg [ADDR_W-1:0] addr_q;
	reg [DATA_W-1:0] rdata_q;
	reg pend_q;
	reg rd_q;
	reg fetch_q;
	reg [3:0] st_q;
	reg [1:0] ph_q;
	reg ea_q;
	reg rst_seen_q;
	reg nmi_q;
	reg aw_q;
	reg w_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg wstrb0_q;

	wire dyn_w = cfg_q[`EMB_CFG_WIDTH16_BIT] & cfg2_q[`EMB_CFG2_WIDTH8_BIT];
	wire illegal_w = ~cfg_q[`EMB_CFG_WIDTH16_BIT] & ~cfg2_q[`EMB_CFG2_WIDTH8_BIT];
	wire adv_mode = cfg_q[`EMB_CFG_ADV_BIT];
	// On-chip window only when captured level is high
	wire onchip = ea_q && addr_q >= `EMB_ONCHIP_LO && addr_q <= `EMB_ONCHIP_HI;
	wire held = hold_acknowledge_output;
	wire nmi_rise = nmi_in & ~nmi_q;
	// On-chip fetch finishes this cycle with no bus activity
	wire int_fetch = st_q == ST_IDLE && pend_q && onchip && rd_q && fetch_q;

	// AXI write path: address and data accepted in either order
	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire wr_fire = aw_q & w_q & ~s_axi_bvalid;
	wire [7:0] wa = awaddr_q;
	wire go_wr = wr_fire && wa == `EMB_REQ_OFS && wdata_q[`EMB_REQ_GO_BIT];
	wire cyc_done = st_q == ST_END && ph_q == 2'd0;

	// Illegal width flag re-arms every cycle while the setting stands
	wire [`EMB_IRQ_W-1:0] irq_set = {illegal_w, hold_acknowledge_output == 1'b0 && hold_request && st_q == ST_IDLE,
		cyc_done, nmi_rise};
	wire [`EMB_IRQ_W-1:0] irq_clr = (wr_fire && wa == `EMB_IRQ_OFS) ? wdata_q[`EMB_IRQ_W-1:0] : {`EMB_IRQ_W{1'b0}};
	assign irq = |(irq_q & mask_q[`EMB_IRQ_W-1:0]);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb0_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				// Lane enable kept with its data; master may change it afterwards
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa <= `EMB_RDATA_OFS && wa[1:0] == 2'b00) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Registers; config and mask take byte lane 0 only, address takes the low 24 bits
	always @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `EMB_CFG_RST;
			cfg2_q <= `EMB_CFG2_RST;
			mask_q <= 8'h00;
			irq_q <= {`EMB_IRQ_W{1'b0}};
			addr_q <= {ADDR_W{1'b0}};
		end else begin
			// Set wins over a same-cycle clear
			irq_q <= (irq_q & ~irq_clr) | irq_set;
			if (wr_fire && s_axi_bvalid == 1'b0 && wstrb0_q) begin
				case (wa)
				`EMB_CFG_OFS: cfg_q <= wdata_q[7:0];
				`EMB_CFG2_OFS: cfg2_q <= wdata_q[7:0];
				`EMB_MASK_OFS: mask_q <= wdata_q[7:0];
				default: ;
				endcase
			end
			if (wr_fire && wa == `EMB_ADDR_OFS && st_q == ST_IDLE && !pend_q)
				addr_q <= wdata_q[ADDR_W-1:0];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
			`EMB_CFG_OFS: s_axi_rdata <= {24'h000000, cfg_q};
			`EMB_CFG2_OFS: s_axi_rdata <= {24'h000000, cfg2_q};
			`EMB_REQ_OFS: s_axi_rdata <= {29'h00000000, fetch_q, rd_q, pend_q};
			`EMB_STAT_OFS: s_axi_rdata <= {24'h000000, illegal_w, programming_mode, ea_q,
				pending_cycle_request, held, bus_width16, st_q == ST_IDLE, pend_q};
			`EMB_IRQ_OFS: s_axi_rdata <= {{(32-`EMB_IRQ_W){1'b0}}, irq_q};
			`EMB_MASK_OFS: s_axi_rdata <= {24'h000000, mask_q};
			`EMB_ADDR_OFS: s_axi_rdata <= {{(32-ADDR_W){1'b0}}, addr_q};
			`EMB_RDATA_OFS: s_axi_rdata <= {{(32-DATA_W){1'b0}}, rdata_q};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Divided clock, toggles every edge: half rate, 50% duty
	always @(posedge aclk) begin
		if (!aresetn)
			divided_clock_output <= 1'b0;
		else
			divided_clock_output <= ~divided_clock_output;
	end

	// External access level caught on the first edge after release
	always @(posedge aclk) begin
		if (!aresetn) begin
			ea_q <= 1'b0;
			rst_seen_q <= 1'b0;
			programming_mode <= 1'b0;
			// Later pin changes wait for the next reset
		end else if (!rst_seen_q) begin
			rst_seen_q <= 1'b1;
			ea_q <= external_access_input;
			programming_mode <= external_access_prog;
		end
	end

	// NMI edge detection; vector presented on rising edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			nmi_q <= 1'b0;
			nmi_vector <= {ADDR_W{1'b0}};
		end else begin
			nmi_q <= nmi_in;
			if (nmi_rise)
				nmi_vector <= `EMB_NMI_VECTOR;
		end
	end

	// Hold handshake: bus released only between cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_acknowledge_output <= 1'b0;
			pending_cycle_request <= 1'b0;
		end else begin
			if (hold_request && st_q == ST_IDLE)
				hold_acknowledge_output <= 1'b1;
			else if (!hold_request)
				hold_acknowledge_output <= 1'b0;
			// On-chip work never needs the bus, so it raises no request
			pending_cycle_request <= held & hold_request & pend_q & ~onchip;
		end
	end

	// Bus cycle sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			ph_q <= 2'd0;
			pend_q <= 1'b0;
			rd_q <= 1'b0;
			fetch_q <= 1'b0;
			rdata_q <= {DATA_W{1'b0}};
			bus_addr <= {ADDR_W{1'b0}};
			bus_width16 <= 1'b0;
		end else begin
			// A go while busy is dropped, not queued
			if (go_wr && !pend_q) begin
				pend_q <= 1'b1;
				rd_q <= wdata_q[`EMB_REQ_READ_BIT];
				fetch_q <= wdata_q[`EMB_REQ_FETCH_BIT];
			end
			case (st_q)
			ST_IDLE: begin
				// Internal accesses complete without any bus activity
				if (pend_q && onchip) begin
					pend_q <= 1'b0;
				end else if (pend_q && !held && !hold_request) begin
					st_q <= ST_ADDR;
					ph_q <= PH_LAST;
					bus_addr <= addr_q;
				end
			end
			ST_ADDR: begin
				if (ph_q == 2'd0) begin
					st_q <= ST_DATA;
					ph_q <= PH_LAST;
					// Width fixed before data phase
					bus_width16 <= dyn_w ? width_select_in : cfg_q[`EMB_CFG_WIDTH16_BIT];
				end else
					ph_q <= ph_q - 2'd1;
			end
			ST_DATA: begin
				if (ph_q == 2'd0) begin
					st_q <= ST_END;
					ph_q <= 2'd0;
					if (rd_q)
						rdata_q <= bus_width16 ? bus_data_in : {{(DATA_W-8){1'b0}}, bus_data_in[7:0]};
				end else
					ph_q <= ph_q - 2'd1;
			end
			ST_END: begin
				st_q <= ST_IDLE;
				pend_q <= 1'b0;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Pin drive; general port value when the bus function is not active, except address strobe held high in address valid mode
	wire ext_cyc = st_q != ST_IDLE;
	always @(posedge aclk) begin
		if (!aresetn) begin
			address_valid_strobe <= 1'b1;
			read_strobe_n <= 1'b1;
			fetch_indicator <= 1'b0;
		end else begin
			// Latch enable high during address phase; valid low through the cycle
			if (adv_mode)
				address_valid_strobe <= ~((st_q == ST_IDLE && pend_q && !onchip && !held && !hold_request) ||
					st_q == ST_ADDR || st_q == ST_DATA);
			else if (ext_cyc || (pend_q && !onchip && !held && !hold_request))
				address_valid_strobe <= (st_q == ST_IDLE) || (st_q == ST_ADDR && ph_q != 2'd0);
			else
				address_valid_strobe <= general_port_pin[0];
			read_strobe_n <= (st_q == ST_DATA || (st_q == ST_ADDR && ph_q == 2'd0)) && rd_q ? 1'b0 :
				(ext_cyc ? 1'b1 : general_port_pin[1]);
			// Fetch indicator for whole external read cycle only
			if (ext_cyc || (st_q == ST_IDLE && pend_q && !onchip && !held && !hold_request))
				fetch_indicator <= rd_q & fetch_q & ~(st_q == ST_END);
			else if (int_fetch)
				// Port value must not leak out as a fetch flag
				fetch_indicator <= 1'b0;
			else
				fetch_indicator <= general_port_pin[2];
		end
	end
endmodule // emb_bus_ctrl
`default_nettype wire

// File: tb/emb_chk_assertions.sv
// Concurrent checks on the external bus control pins
`timescale 1ns/10ps
`default_nettype none
module emb_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic divided_clock_output,
	input wire logic nmi_in,
	input wire logic [23:0] nmi_vector,
	input wire logic hold_request,
	input wire logic hold_acknowledge_output,
	input wire logic pending_cycle_request,
	input wire logic read_strobe_n,
	input wire logic fetch_indicator
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence grant_s;
		##[1:16] hold_acknowledge_output;
	endsequence
	sequence rd_data_s;
		!read_strobe_n ##1 !read_strobe_n ##1 read_strobe_n;
	endsequence
	a_clk_half: assert property ($past(aresetn) |-> divided_clock_output != $past(divided_clock_output))
		else $error("clock out missed a toggle");
	a_nmi_vector: assert property ($rose(nmi_in) |-> ##[1:3] nmi_vector == 24'h00203E)
		else $error("nmi vector not loaded");
	a_hold_grant: assert property ($rose(hold_request) |-> grant_s)
		else $error("hold not granted");
	a_hold_drop: assert property (!hold_request |-> ##[0:3] !hold_acknowledge_output)
		else $error("hold ack stays without request");
	a_held_quiet: assert property (hold_acknowledge_output |-> read_strobe_n)
		else $error("read strobe while bus released");
	a_pending_cycle_request_held: assert property (pending_cycle_request |-> hold_acknowledge_output || $past(hold_acknowledge_output))
		else $error("bus request while owning bus");
	a_rd_pulse: assert property ($fell(read_strobe_n) |=> rd_data_s)
		else $error("read strobe length wrong");
	a_fetch_valid: assert property ($fell(read_strobe_n) && fetch_indicator |=> fetch_indicator)
		else $error("fetch indicator dropped in cycle");
endmodule // emb_chk
bind emb_bus_ctrl emb_chk chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.divided_clock_output(divided_clock_output),
	.nmi_in(nmi_in),
	.nmi_vector(nmi_vector),
	.hold_request(hold_request),
	.hold_acknowledge_output(hold_acknowledge_output),
	.pending_cycle_request(pending_cycle_request),
	.read_strobe_n(read_strobe_n),
	.fetch_indicator(fetch_indicator)
);
`default_nettype wire

// File: tb/emb_mem.sv
// External memory and width select partner
`timescale 1ns/10ps
`default_nettype none
module emb_mem (
	// Bus side
	input wire logic aclk,
	input wire logic read_strobe_n,
	input wire logic [23:0] bus_addr,
	input wire logic want16,
	output logic width_select_in,
	output logic [15:0] bus_data_in
);
	logic flip_q = 1'b0;
	always @(posedge aclk) begin
		flip_q <= !flip_q;
	end
	assign width_select_in = want16;
	// Released bus churns so stale data never passes
	assign bus_data_in = read_strobe_n ? {8{flip_q, !flip_q}} : bus_addr[15:0] ^ 16'hA5C3;
endmodule // emb_mem
`default_nettype wire

// File: tb/tb_emb_bus_ctrl.sv
// Self-checking bench for the external bus control
`timescale 1ns/10ps
`default_nettype none
module tb_emb_bus_ctrl;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, bry = 0, rry = 0;
	logic ea = 1, prog = 0, nmi = 0, hold = 0, w16 = 0, sr = 0, sf = 0, s16 = 0, sa = 0;
	logic [1:0] bs = 0, rs = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [3:0] gp = 4'h2;
	wire awr, wry, arr, bv, rv, ws, fi, avs, rdn, hla, pcr, w16o, pm, irq, dco;
	wire [1:0] brs, rrs;
	wire [31:0] rdt;
	wire [23:0] ba, nv;
	wire [15:0] bd;
	int mismatches = 0, checks_done = 0;
	initial forever #20 aclk = !aclk;
	emb_bus_ctrl emb_bus_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wry),
		.s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.divided_clock_output(dco), .width_select_in(ws), .nmi_in(nmi), .external_access_input(ea),
		.external_access_prog(prog), .fetch_indicator(fi), .address_valid_strobe(avs), .read_strobe_n(rdn),
		.hold_request(hold), .hold_acknowledge_output(hla), .pending_cycle_request(pcr), .bus_addr(ba),
		.bus_data_in(bd), .bus_width16(w16o), .general_port_pin(gp), .programming_mode(pm), .nmi_vector(nv),
		.irq(irq));
	emb_mem emb_mem_i (.aclk(aclk), .read_strobe_n(rdn), .bus_addr(ba), .want16(w16), .width_select_in(ws),
		.bus_data_in(bd));
	always @(posedge aclk) if (!rdn) begin
		sr <= 1;
		sf <= fi;
		s16 <= w16o;
	end
	always @(posedge aclk) if (!avs) sa <= 1;
	task automatic end_of_test;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tmo(input int c);
		if (c > 99) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tbv;
		int n;
		n = 0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(negedge aclk);
			ta = awr & awv;
			tw = wry & wv;
			tbv = bv;
			bs = brs;
			@(posedge aclk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			tmo(n++);
		end while (!tbv);
		bry <= 0;
	endtask
	task automatic rdr(input logic [7:0] a);
		logic ta, tr;
		int n;
		n = 0;
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(negedge aclk);
			ta = arr & arv;
			tr = rv;
			rd = rdt;
			rs = rrs;
			@(posedge aclk);
			if (ta) arv <= 0;
			tmo(n++);
		end while (!tr);
		rry <= 0;
	endtask
	task automatic cyc(input logic [23:0] a, input logic [2:0] f);
		int k;
		k = 0;
		wr(8'h18, {8'h00, a});
		sr <= 0;
		sf <= 0;
		sa <= 0;
		wr(8'h08, {29'h0, f});
		do begin
			rdr(8'h0C);
			tmo(k++);
		end while (rd[0]);
	endtask
	task automatic rst(input logic e, input logic p);
		aresetn <= 0;
		ea <= e;
		prog <= p;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
	endtask
	function automatic logic [31:0] xd(input logic [23:0] a, input logic w);
		logic [15:0] p;
		p = a[15:0] ^ 16'hA5C3;
		return w ? {16'h0, p} : {24'h0, p[7:0]};
	endfunction
	initial begin
		logic [31:0] r;
		logic [23:0] a;
		logic e16;
		int i, m, k;
		void'($urandom(32'h1226C21C));
		rst(1, 0);
		@(negedge aclk);
		r[0] = dco;
		@(negedge aclk);
		chk(dco, !r[0]);
		rdr(8'h00);
		chk(rd, 32'h02);
		rdr(8'h04);
		chk(rd, 32'h04);
		rdr(8'h24);
		chk(rd, 32'h0);
		chk(rs, 2'b10);
		wr(8'h24, 32'h1);
		chk(bs, 2'b10);
		wr(8'h14, 32'hF);
		chk(bs, 2'b00);
		// Mode 3 is the illegal setting, expected to fall back to 8-bit
		for (i = 0; i < 16; i++) begin
			m = i % 4;
			r = $urandom;
			wr(8'h00, (m == 1 || m == 3) ? {29'h0, r[3], 2'b00} : {29'h0, r[3], 2'b10});
			wr(8'h04, (m == 2 || m == 3) ? 32'h0 : 32'h4);
			w16 <= r[0];
			e16 = m == 2 || (m == 0 && r[0]);
			a = {8'h10, r[23:8]};
			cyc(a, {r[1], r[2], 1'b1});
			chk(sr, r[2]);
			chk(sf, r[1] & r[2]);
			chk(avs, r[3] ? 1'b1 : gp[0]);
			if (r[3]) chk(sa, 1);
			if (r[2]) chk(s16, e16);
			rdr(8'h1C);
			if (r[2]) chk(rd, xd(a, e16));
		end
		rdr(8'h10);
		chk(rd[3:0] & 4'hA, 4'hA);
		// Legal fixed 8-bit width, address valid mode until the next reset
		wr(8'h04, 32'h4);
		wr(8'h00, 32'h4);
		wr(8'h10, 32'hF);
		nmi <= 1;
		repeat (2) @(posedge aclk);
		nmi <= 0;
		rdr(8'h10);
		chk(rd[3:0], 4'h1);
		chk(nv, 24'h00203E);
		@(negedge aclk);
		chk(irq, 1);
		wr(8'h14, 32'h0);
		@(negedge aclk);
		chk(irq, 0);
		wr(8'h10, 32'hF);
		hold <= 1;
		wr(8'h18, 32'h100040);
		sr <= 0;
		sa <= 0;
		wr(8'h08, 32'h3);
		k = 0;
		while (pcr !== 1'b1) begin
			@(posedge aclk);
			tmo(k++);
		end
		chk(hla, 1);
		chk(sr, 0);
		chk(sa, 0);
		hold <= 0;
		k = 0;
		do begin
			rdr(8'h0C);
			tmo(k++);
		end while (rd[0]);
		chk(sr, 1);
		chk(sa, 1);
		rdr(8'h1C);
		chk(rd, xd(24'h100040, 1'b0));
		cyc(24'hFF2000, 3'b111);
		chk(sr, 0);
		chk(sa, 0);
		rst(0, 1);
		ea <= 1;
		rdr(8'h0C);
		chk(rd[6:5], 2'b10);
		chk(pm, 1);
		cyc(24'hFF2000, 3'b111);
		chk(sr, 1);
		chk(sf, 1);
		gp <= 4'h7;
		wr(8'h00, 32'h2);
		@(negedge aclk);
		chk(avs, 1);
		chk(fi, 1);
		end_of_test();
	end
endmodule // tb_emb_bus_ctrl
`default_nettype wire
